//--- inc/ebi_map.svh
// register offsets, field positions, reset values and timing counts of the external bus block
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
`define EBI_CTRL_IDX 19'h0_0000
`define EBI_STAT_IDX 19'h0_0001
`define EBI_EXT_SEL_BIT 20
`define EBI_CTRL_SINGLE_BIT 0
`define EBI_CTRL_MUX_BIT 1
`define EBI_CTRL_MICRO_BIT 2
`define EBI_STAT_WIDTH8_BIT 0
`define EBI_STAT_HOLD_BIT 1
`define EBI_STAT_BOOT_BIT 2
`define EBI_CTRL_SINGLE_RST 1'b0
`define EBI_CTRL_MUX_RST 1'b0
`define EBI_CLK_NS 10
`define EBI_STROBE_NS 40
`define EBI_STROBE_CYC ((`EBI_STROBE_NS + `EBI_CLK_NS - 1) / `EBI_CLK_NS)
`define EBI_SETTLE_CYC 3'h5
`endif

//--- inc/ebi_pkg.sv
// types of the external bus block
package ebi_pkg;
  typedef enum logic [2:0] {
    EBI_INIT,
    EBI_IDLE,
    EBI_ADDR,
    EBI_STROBE,
    EBI_DONE,
    EBI_HOLD
  } ebi_state_t;

  // synchronised pin inputs, one vector so the three flip-flop chain is shared
  typedef struct packed {
    logic boot;
    logic width8;
    logic hold_n;
    logic wait_n;
    logic [7:0] dhi;
    logic [7:0] dlo;
  } ebi_pins_t;

  typedef struct packed {
    ebi_state_t st;
    logic [7:0] cnt;
    logic [2:0] init;
    ebi_pins_t s1;
    ebi_pins_t s2;
    ebi_pins_t s3;
    ebi_pins_t f;
    logic single_strobe;
    logic muxed;
    logic micro;
    logic width8;
    logic boot;
    logic rq_wr;
    logic rq_odd;
    logic rq_word;
    logic [15:0] rq_wdata;
    logic [19:0] addr_o;
    logic [7:0] dlo_o;
    logic [7:0] dhi_o;
    logic dlo_oe_n;
    logic dhi_oe_n;
    logic ale;
    logic rd_n;
    logic wrl_n;
    logic wrh_n;
    logic [3:0] cs_n;
    logic ack_n;
    logic micro_o;
    logic waitreq;
    logic [31:0] rdata;
  } ebi_regs_t;
endpackage

//--- verilog/ebi_bus.sv
// external memory bus controller with an Avalon-MM register and access port
// Operation
// - held in reset state for as long as rst_n is low
// - boot strap low at reset: single-chip mode, external bus idle
// - boot strap high at reset: microprocessor mode, external bus in use
// - width strap low gives 16-bit bus, high gives 8-bit; strap stays fixed
// - separate bus: low data byte driven and sampled on low data lines
// - 16-bit separate bus: high data byte on upper data lines
// - address driven on twenty lines, bits zero through nineteen
// - 8-bit multiplexed: shared lines carry address bits 0-7, then data
// - 16-bit multiplexed: shared lines carry address bits 1-8, then data
// - four chip selects, each for one quarter of external space
// - software picks split write strobes or single write plus upper-lane enable
// - split form: low-byte write strobe low on writes to even address
// - split form: high-byte write strobe low on writes to odd address
// - read strobe low while reading, in either form
// - single form: common write strobe low on any write
// - single form: upper-lane enable low on any odd address access
// - address latch strobe lets outside logic capture the address
// - hold request low keeps the block in hold, no bus cycles
// - release acknowledge low while in hold
// - wait request low extends the current access
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "ebi_map.svh"
module ebi_bus
  import ebi_pkg::*;
#(
  parameter int STROBE_CYC = `EBI_STROBE_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [20:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic boot_mode_strap,
  input wire logic bus_width_strap,
  input wire logic bus_release_req_n,
  input wire logic wait_req_n,
  output logic bus_release_ack_n,
  output logic micro_mode,
  output logic [19:0] ext_addr,
  input wire logic [7:0] data_lo_in,
  output logic [7:0] data_lo_out,
  output logic data_lo_oe_n,
  input wire logic [7:0] data_hi_in,
  output logic [7:0] data_hi_out,
  output logic data_hi_oe_n,
  output logic addr_latch,
  output logic read_strobe_n,
  output logic low_byte_store_strobe_n,
  output logic high_byte_store_strobe_n,
  output logic space_select_0_n,
  output logic space_select_1_n,
  output logic space_select_2_n,
  output logic space_select_3_n
);

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  ebi_regs_t q;
  ebi_regs_t d;
  ebi_pins_t pins_in;
  logic ext_sel;
  logic [19:0] rq_addr;
  logic rq_odd;
  logic rq_word;

  // chip select for the quarter of the space that holds the address
  function automatic logic [3:0] space_decode(input logic [19:0] a);
    logic [3:0] sel;
    sel = 4'hF;
    sel[a[19:18]] = 1'b0;
    return sel;
  endfunction

  assign pins_in = '{boot: boot_mode_strap, width8: bus_width_strap,
                     hold_n: bus_release_req_n, wait_n: wait_req_n,
                     dhi: data_hi_in, dlo: data_lo_in};
  assign ext_sel = avs_address[`EBI_EXT_SEL_BIT];
  // odd byte only on the upper lane; a word only on a 16-bit bus
  assign rq_odd = (avs_byteenable[1:0] == 2'h2);
  assign rq_word = (avs_byteenable[1:0] == 2'h3) && !q.width8;
  assign rq_addr = {avs_address[18:0], rq_odd};

  always_comb
  begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a pin change counts once the second and third stages agree
    d.f = (q.f & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    d.waitreq = 1'b1;
    d.ale = 1'b0;
    d.rd_n = 1'b1;
    d.wrl_n = 1'b1;
    d.wrh_n = 1'b1;
    d.cs_n = 4'hF;
    d.ack_n = 1'b1;
    d.micro_o = q.micro;
    case (q.st)
      EBI_INIT:
      begin
        d.init = q.init + 3'h1;
        if (q.init == `EBI_SETTLE_CYC)
        begin
          // straps caught once the input chain has settled after release
          d.boot = q.f.boot;
          d.micro = q.f.boot;
          d.width8 = q.f.width8;
          d.single_strobe = q.f.width8 | `EBI_CTRL_SINGLE_RST;
          d.st = EBI_IDLE;
        end
      end
      EBI_IDLE:
      begin
        d.dlo_oe_n = 1'b1;
        d.dhi_oe_n = 1'b1;
        if (!q.f.hold_n)
        begin
          d.ack_n = 1'b0;
          d.st = EBI_HOLD;
        end
        else if ((avs_read || avs_write) && ext_sel && q.micro)
        begin
          d.rq_wr = avs_write;
          d.rq_odd = rq_odd;
          d.rq_word = rq_word;
          d.rq_wdata = avs_writedata[15:0];
          d.addr_o = rq_addr;
          d.cs_n = space_decode(rq_addr);
          d.ale = 1'b1;
          if (q.muxed)
          begin
            // address phase on the shared lines
            d.dlo_o = q.width8 ? rq_addr[7:0] : rq_addr[8:1];
            d.dlo_oe_n = 1'b0;
          end
          d.st = EBI_ADDR;
        end
        else if (avs_read || avs_write)
        begin
          // registers, or an external access refused in single-chip mode
          d.rdata = 32'h0000_0000;
          if (!ext_sel && avs_address[18:0] == `EBI_CTRL_IDX)
          begin
            d.rdata[`EBI_CTRL_SINGLE_BIT] = q.single_strobe;
            d.rdata[`EBI_CTRL_MUX_BIT] = q.muxed;
            d.rdata[`EBI_CTRL_MICRO_BIT] = q.micro;
          end
          else if (!ext_sel && avs_address[18:0] == `EBI_STAT_IDX)
          begin
            d.rdata[`EBI_STAT_WIDTH8_BIT] = q.width8;
            d.rdata[`EBI_STAT_HOLD_BIT] = !q.f.hold_n;
            d.rdata[`EBI_STAT_BOOT_BIT] = q.boot;
          end
          d.rq_wr = 1'b0;
          d.waitreq = 1'b0;
          d.st = EBI_DONE;
        end
      end
      EBI_ADDR:
      begin
        // latch strobe falls here, lines turn to data at the same edge
        d.cs_n = q.cs_n;
        d.cnt = 8'h00;
        d.dlo_oe_n = 1'b1;
        d.dhi_oe_n = 1'b1;
        if (q.rq_wr)
        begin
          if (q.width8)
          begin
            d.dlo_o = q.rq_odd ? q.rq_wdata[15:8] : q.rq_wdata[7:0];
            d.dlo_oe_n = 1'b0;
          end
          else
          begin
            d.dlo_o = q.rq_wdata[7:0];
            d.dhi_o = q.rq_wdata[15:8];
            d.dlo_oe_n = !(q.rq_word || !q.rq_odd);
            // multiplexed odd byte rides the shared lines, words still use both lanes
            d.dhi_oe_n = !(q.rq_word || (q.rq_odd && !q.muxed));
            if (q.muxed && q.rq_odd)
            begin
              // multiplexed 16-bit bus carries the odd byte on the shared lines
              d.dlo_o = q.rq_wdata[15:8];
              d.dlo_oe_n = 1'b0;
            end
          end
          if (q.single_strobe)
          begin
            d.wrl_n = 1'b0;
            d.wrh_n = !(q.rq_odd || q.rq_word);
          end
          else
          begin
            d.wrl_n = !(q.rq_word || !q.rq_odd);
            d.wrh_n = !(q.rq_word || q.rq_odd);
          end
        end
        else
        begin
          d.rd_n = 1'b0;
          if (q.single_strobe)
          begin
            d.wrh_n = !(q.rq_odd || q.rq_word);
          end
        end
        d.st = EBI_STROBE;
      end
      EBI_STROBE:
      begin
        d.cs_n = q.cs_n;
        d.rd_n = q.rd_n;
        d.wrl_n = q.wrl_n;
        d.wrh_n = q.wrh_n;
        if (q.cnt != STROBE_LAST)
        begin
          d.cnt = q.cnt + 8'h01;
        end
        else if (q.f.wait_n)
        begin
          d.rd_n = 1'b1;
          d.wrl_n = 1'b1;
          d.wrh_n = 1'b1;
          d.cs_n = 4'hF;
          d.dlo_oe_n = 1'b1;
          d.dhi_oe_n = 1'b1;
          d.rdata = 32'h0000_0000;
          if (q.width8 || (q.muxed && q.rq_odd))
          begin
            if (q.rq_odd)
            begin
              d.rdata[15:8] = q.f.dlo;
            end
            else
            begin
              d.rdata[7:0] = q.f.dlo;
            end
          end
          else
          begin
            d.rdata[15:0] = {q.f.dhi, q.f.dlo};
          end
          d.waitreq = 1'b0;
          d.st = EBI_DONE;
        end
      end
      EBI_DONE:
      begin
        // the master takes the answer at this edge; software writes land here too
        if (avs_write && !ext_sel && avs_address[18:0] == `EBI_CTRL_IDX && avs_byteenable[0])
        begin
          d.single_strobe = avs_writedata[`EBI_CTRL_SINGLE_BIT];
          d.muxed = avs_writedata[`EBI_CTRL_MUX_BIT];
          d.micro = avs_writedata[`EBI_CTRL_MICRO_BIT];
        end
        d.st = EBI_IDLE;
      end
      EBI_HOLD:
      begin
        d.dlo_oe_n = 1'b1;
        d.dhi_oe_n = 1'b1;
        d.ack_n = q.f.hold_n;
        if (q.f.hold_n)
        begin
          d.st = EBI_IDLE;
        end
      end
      default:
      begin
        d.st = EBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= EBI_INIT;
      q.s1 <= '1;
      q.s2 <= '1;
      q.s3 <= '1;
      q.f <= '1;
      q.muxed <= `EBI_CTRL_MUX_RST;
      q.dlo_oe_n <= 1'b1;
      q.dhi_oe_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wrl_n <= 1'b1;
      q.wrh_n <= 1'b1;
      q.cs_n <= 4'hF;
      q.ack_n <= 1'b1;
      q.waitreq <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign bus_release_ack_n = q.ack_n;
  assign micro_mode = q.micro_o;
  assign ext_addr = q.addr_o;
  assign data_lo_out = q.dlo_o;
  assign data_lo_oe_n = q.dlo_oe_n;
  assign data_hi_out = q.dhi_o;
  assign data_hi_oe_n = q.dhi_oe_n;
  assign addr_latch = q.ale;
  assign read_strobe_n = q.rd_n;
  assign low_byte_store_strobe_n = q.wrl_n;
  assign high_byte_store_strobe_n = q.wrh_n;
  assign space_select_0_n = q.cs_n[0];
  assign space_select_1_n = q.cs_n[1];
  assign space_select_2_n = q.cs_n[2];
  assign space_select_3_n = q.cs_n[3];
endmodule

//--- testbench/ebi_bus_properties.sv
// concurrent checks on the pins of the external bus block
module ebi_props
  import ebi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic avs_waitrequest,
  input wire logic bus_release_req_n,
  input wire logic bus_release_ack_n,
  input wire logic micro_mode,
  input wire logic [19:0] ext_addr,
  input wire logic data_lo_oe_n,
  input wire logic data_hi_oe_n,
  input wire logic addr_latch,
  input wire logic read_strobe_n,
  input wire logic low_byte_store_strobe_n,
  input wire logic high_byte_store_strobe_n,
  input wire logic space_select_0_n,
  input wire logic space_select_1_n,
  input wire logic space_select_2_n,
  input wire logic space_select_3_n,
  input wire logic bus_width_strap,
  input wire logic [7:0] data_lo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sel_n;
  logic strb;
  assign sel_n = {space_select_3_n, space_select_2_n, space_select_1_n, space_select_0_n};
  assign strb = !read_strobe_n || !low_byte_store_strobe_n;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence addr_phase;
    addr_latch && read_strobe_n && low_byte_store_strobe_n;
  endsequence
  sequence data_phase;
    !addr_latch && (strb || !high_byte_store_strobe_n);
  endsequence
  latch_phase_a: assert property (addr_latch |-> addr_phase ##1 data_phase)
    else $error("latch pulse not followed by data phase");
  hold_quiet_a: assert property (!bus_release_ack_n |-> sel_n == 4'hF && !strb
    && high_byte_store_strobe_n) else $error("bus active in hold");
  hold_enter_a: assert property ((!bus_release_req_n && sel_n == 4'hF) [*8]
    |-> !bus_release_ack_n) else $error("hold not acknowledged");
  hold_leave_a: assert property (bus_release_req_n [*8] |-> bus_release_ack_n)
    else $error("hold kept after release");
  read_write_a: assert property (!read_strobe_n |-> low_byte_store_strobe_n)
    else $error("read and write strobes together");
  one_select_a: assert property (strb |-> sel_n == ~(4'h1 << ext_addr[19:18]))
    else $error("wrong chip select");
  strobe_len_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*4])
    else $error("read strobe too short");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  no_bus_a: assert property (!micro_mode |-> sel_n == 4'hF)
    else $error("external cycle in single chip mode");
  drive_dir_a: assert property (!read_strobe_n |-> data_lo_oe_n && data_hi_oe_n)
    else $error("data driven during read");
  mux_addr_a: assert property (addr_latch && !data_lo_oe_n |-> data_lo_out ==
    (bus_width_strap ? ext_addr[7:0] : ext_addr[8:1])) else $error("wrong shared address");
endmodule
bind ebi_bus ebi_props u_props (.mclk, .rst_n, .avs_waitrequest, .bus_release_req_n,
  .bus_release_ack_n, .micro_mode, .ext_addr, .data_lo_oe_n, .data_hi_oe_n, .addr_latch,
  .read_strobe_n, .low_byte_store_strobe_n, .high_byte_store_strobe_n, .space_select_0_n,
  .space_select_1_n, .space_select_2_n, .space_select_3_n, .bus_width_strap, .data_lo_out);

//--- testbench/ebi_mem_model.sv
// byte memory standing on the far side of the external bus
module ebi_mem_model
  import ebi_pkg::*;
(
  input wire logic mclk,
  input wire logic single,
  input wire logic slow,
  input wire logic w8,
  input wire logic [19:0] ext_addr,
  input wire logic [7:0] dlo,
  input wire logic [7:0] dhi,
  input wire logic lo_oe_n,
  input wire logic hi_oe_n,
  input wire logic lo_n,
  input wire logic hi_n,
  input wire logic [3:0] sel_n,
  output logic [7:0] qlo,
  output logic [7:0] qhi,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [3:0] wc = 4'h0;
  logic [7:0] e;
  logic sel;
  logic [7:0] lo;
  logic [7:0] hi;
  // a byte bus addresses every byte, a word bus pairs them
  assign e = w8 ? ext_addr[7:0] : {ext_addr[7:1], 1'b0};
  // a lane the block does not drive is stored as the inverted byte
  assign lo = dlo ^ {8{lo_oe_n}};
  assign hi = dhi ^ {8{hi_oe_n}};
  assign sel = sel_n != 4'hF;
  // unselected lines show the inverted byte so stale data cannot match
  assign qlo = sel ? mem[e] : ~mem[e];
  assign qhi = sel ? mem[e | 8'h01] : ~mem[e | 8'h01];
  assign wait_n = !(slow && sel && wc < 4'hA);
  always @(posedge mclk)
  begin
    wc <= sel ? wc + {3'h0, wc != 4'hF} : 4'h0;
    if (!lo_n && (!single || !ext_addr[0] || w8)) mem[e] <= lo;
    if (!w8 && (single ? !lo_n && !hi_n : !hi_n)) mem[e | 8'h01] <= hi;
  end
endmodule

//--- testbench/ebi_bus_bench.sv
// self-checking bench of the external bus block
module ebi_bus_bench
  import ebi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [20:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [3:0] avs_byteenable = '0, sel_n;
  logic boot_mode_strap = 1'b1, bus_width_strap = 1'b0, bus_release_req_n = 1'b1;
  logic avs_waitrequest, wait_req_n, bus_release_ack_n, micro_mode, sgl = 1'b0, slow = 1'b0;
  logic [19:0] ext_addr;
  logic [7:0] data_lo_in, data_lo_out, data_hi_in, data_hi_out;
  logic data_lo_oe_n, data_hi_oe_n, addr_latch, read_strobe_n;
  logic low_byte_store_strobe_n, high_byte_store_strobe_n;
  logic space_select_0_n, space_select_1_n, space_select_2_n, space_select_3_n;
  logic [7:0] ex [256] = '{default: 8'h00};
  int fail_count = 0;
  int samples_checked = 0;
  assign sel_n = {space_select_3_n, space_select_2_n, space_select_1_n, space_select_0_n};
  ebi_bus #(.STROBE_CYC(4)) u_dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .boot_mode_strap,
    .bus_width_strap, .bus_release_req_n, .wait_req_n, .bus_release_ack_n, .micro_mode,
    .ext_addr, .data_lo_in, .data_lo_out, .data_lo_oe_n, .data_hi_in, .data_hi_out,
    .data_hi_oe_n, .addr_latch, .read_strobe_n, .low_byte_store_strobe_n,
    .high_byte_store_strobe_n, .space_select_0_n, .space_select_1_n, .space_select_2_n,
    .space_select_3_n);
  ebi_mem_model u_mem (.mclk, .single(sgl), .slow, .w8(bus_width_strap), .ext_addr,
    .dlo(data_lo_out), .dhi(data_hi_out), .lo_oe_n(data_lo_oe_n), .hi_oe_n(data_hi_oe_n),
    .lo_n(low_byte_store_strobe_n), .hi_n(high_byte_store_strobe_n),
    .sel_n, .qlo(data_lo_in), .qhi(data_hi_in), .wait_n(wait_req_n));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [20:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] rd, output int n);
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic do_reset(input logic b, input logic w);
    @(posedge mclk);
    rst_n <= 1'b0;
    boot_mode_strap <= b;
    bus_width_strap <= w;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask
  // random word index, write with the given lanes, then read the word back
  task automatic xfer(input logic [3:0] be);
    logic [18:0] n;
    logic [31:0] d, rd, r2;
    logic [7:0] b;
    int c;
    n = 19'($urandom);
    d = $urandom;
    b = {n[6:0], 1'b0};
    r2 = 32'h0;
    acc(1'b1, {2'b10, n}, d, be, rd, c);
    if (be[0]) ex[b] = d[7:0];
    // a byte bus stores only the even byte when both lanes are enabled
    if (be[1] && !(be[0] && bus_width_strap)) ex[b + 8'h01] = d[15:8];
    acc(1'b0, {2'b10, n}, 32'h0, bus_width_strap ? 4'h1 : 4'h3, rd, c);
    if (bus_width_strap) acc(1'b0, {2'b10, n}, 32'h0, 4'h2, r2, c);
    chk(bus_width_strap ? {r2[15:8], rd[7:0]} : rd[15:0], {ex[b + 8'h01], ex[b]});
    if (slow) chk(32'(c > 9), 32'h1);
  endtask
  // set strobe and bus form, read the setting back, then run transfers in it
  task automatic run_mode(input logic [3:0] m);
    logic [31:0] rd;
    int c;
    sgl = m[0];
    acc(1'b1, 21'h0, {28'h0, m}, 4'hF, rd, c);
    acc(1'b0, 21'h0, 32'h0, 4'hF, rd, c);
    chk(rd, {28'h0, m});
    repeat (6) xfer(m[1] && !bus_width_strap ? 4'h3 : 4'($urandom_range(1, 3)));
  endtask
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
  initial
  begin
    logic [31:0] rd;
    int c;
    void'($urandom(32'h5FEC8F8F));
    do_reset(1'b1, 1'b0);
    chk({31'h0, micro_mode}, 32'h1);
    acc(1'b1, 21'h1, 32'h0, 4'hF, rd, c);
    acc(1'b0, 21'h1, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h4);
    acc(1'b0, 21'h0, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h4);
    acc(1'b0, 21'h5, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h0);
    $display("test registers done");
    run_mode(4'h4);
    run_mode(4'h6);
    run_mode(4'h5);
    $display("test modes done");
    slow = 1'b1;
    xfer(4'h3);
    slow = 1'b0;
    $display("test wait done");
    bus_release_req_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({31'h0, bus_release_ack_n}, 32'h0);
    fork
      xfer(4'h3);
      begin
        repeat (20) @(posedge mclk);
        bus_release_req_n <= 1'b1;
      end
    join
    $display("test hold done");
    do_reset(1'b1, 1'b1);
    chk({31'h0, micro_mode}, 32'h1);
    acc(1'b0, 21'h1, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h5);
    acc(1'b0, 21'h0, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h5);
    run_mode(4'h5);
    run_mode(4'h7);
    $display("test byte bus done");
    do_reset(1'b0, 1'b1);
    chk({31'h0, micro_mode}, 32'h0);
    acc(1'b0, 21'h1, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h1);
    acc(1'b0, 21'h0, 32'h0, 4'hF, rd, c);
    chk(rd, 32'h1);
    acc(1'b0, 21'h10_0004, 32'h0, 4'h3, rd, c);
    chk(rd, 32'h0);
    $display("test single chip done");
    end_sim();
  end
endmodule
